// file: inc/adc_glue_pkg.sv
package adc_glue_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 20;
   // software-delay wait for a conversion; plain default, not a part value
   localparam int CONV_WAIT_NS   = 5000;
   localparam int CONV_WAIT_CYC  =
      (CONV_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // width of the convert-start strobe, a least time
   localparam int START_PULSE_NS = 60;
   localparam int START_CYC      =
      (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_W         = 9;

   // ----------------------------------------------------------------
   // converters, results and address map
   // ----------------------------------------------------------------
   localparam int NUM_CONV    = 4;
   localparam int SEL_W       = 2;
   localparam int DATA_W      = 12;
   localparam int NUM_RESULTS = 4;
   localparam int IDX_W       = 2;
   localparam int RES_W       = SEL_W + IDX_W + DATA_W;
   localparam int FIFO_DEPTH  = 16;
   localparam int ADDR_W      = 3;
   localparam logic [ADDR_W-1:0] CONV_BASE  = 3'h0;
   localparam logic [ADDR_W-1:0] START_ADDR = 3'h7;
   localparam logic [ADDR_W-1:0] IDLE_ADDR  = 3'h6;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_START  = 3'b001,
      ST_WAIT   = 3'b010,
      ST_RDADDR = 3'b011,
      ST_RDWAIT = 3'b100,
      ST_RDTAKE = 3'b101,
      ST_RDGAP  = 3'b110
   } seq_state_t;

endpackage

// file: src/result_fifo.sv
`timescale 1ns/10ps
module result_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             i_sys_clk,   // system clock
   input  wire logic             i_nrst,      // async reset, active low
   input  wire logic             i_in_valid,  // write request
   output logic                  o_in_ready,  // room for a word
   input  wire logic [WIDTH-1:0] i_in_data,   // word written
   output logic                  o_out_valid, // output word present
   input  wire logic             i_out_ready, // consumer takes word
   output logic [WIDTH-1:0]      o_out_data   // registered output word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [AW:0]      count_r, count_nxt;
   logic             out_valid_r, out_valid_nxt;
   logic [WIDTH-1:0] out_data_r, out_data_nxt;
   logic             push, pop;

   // ----------------------------------------------------------------
   // pointers and output stage
   // ----------------------------------------------------------------
   always_comb begin
      push          = i_in_valid && (count_r != (AW+1)'(DEPTH));
      pop           = (count_r != '0) && (!out_valid_r || i_out_ready);
      wr_ptr_nxt    = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_nxt    = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_nxt     = count_r + (AW+1)'(push) - (AW+1)'(pop);
      out_data_nxt  = pop ? mem[rd_ptr_r] : out_data_r;
      out_valid_nxt = pop || (out_valid_r && !i_out_ready);
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_ptr_r    <= '0;
         rd_ptr_r    <= '0;
         count_r     <= '0;
         out_valid_r <= 1'b0;
         out_data_r  <= '0;
      end else begin
         wr_ptr_r    <= wr_ptr_nxt;
         rd_ptr_r    <= rd_ptr_nxt;
         count_r     <= count_nxt;
         out_valid_r <= out_valid_nxt;
         out_data_r  <= out_data_nxt;
      end
   end

   // storage has no reset, so it stays plain memory
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= i_in_data;
      end
   end

   assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
   assign o_out_valid = out_valid_r;
   assign o_out_data  = out_data_r;
endmodule

// file: src/adc_host_bus_glue.sv
`timescale 1ns/10ps
module adc_host_bus_glue (
   input  wire logic                 i_sys_clk,          // 50 MHz clock
   input  wire logic                 i_nrst,             // async reset, low
   input  wire logic                 i_start,            // start request
   input  wire logic [1:0]           i_conv_sel,         // converter to read
   input  wire logic                 i_use_busy,         // 1: busy, 0: delay
   input  wire logic                 i_ext_start_n,      // external timer pin
   input  wire logic [3:0]           i_busy,             // busy pins
   input  wire logic [11:0]          i_adc_data,         // shared data pins
   output logic                      o_convert_start_n,  // convert-start
   output logic                      o_rd_n,             // shared read strobe
   output logic [3:0]                o_cs_n,             // chip selects
   output logic                      o_address_strobe_n, // bus cycle strobe
   output logic                      o_rw,               // 1 read, 0 write
   output logic                      o_transfer_ack_n,   // ack from cs
   output logic                      o_active,           // sequence running
   output logic                      o_res_valid,        // result present
   input  wire logic                 i_res_ready,        // result taken
   output logic [15:0]               o_res_data          // {sel,idx,data}
);
   localparam int WAIT_CYC  = adc_glue_pkg::CONV_WAIT_CYC;
   localparam int START_CYC = adc_glue_pkg::START_CYC;
   localparam int AW        = adc_glue_pkg::ADDR_W;
   localparam int WW        = adc_glue_pkg::WAIT_W;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0]  busy_s1_r, busy_s2_r;
   logic [11:0] data_s1_r, data_s2_r;
   logic        ext_s1_r, ext_s2_r, ext_d_r;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy_s1_r <= 4'h0;
         busy_s2_r <= 4'h0;
         data_s1_r <= 12'h000;
         data_s2_r <= 12'h000;
         ext_s1_r  <= 1'b1;
         ext_s2_r  <= 1'b1;
         ext_d_r   <= 1'b1;
      end else begin
         busy_s1_r <= i_busy;
         busy_s2_r <= busy_s1_r;
         data_s1_r <= i_adc_data;
         data_s2_r <= data_s1_r;
         ext_s1_r  <= i_ext_start_n;
         ext_s2_r  <= ext_s1_r;
         ext_d_r   <= ext_s2_r;
      end
   end

   // ----------------------------------------------------------------
   // sequencer and processor-style bus cycle
   // ----------------------------------------------------------------
   adc_glue_pkg::seq_state_t state_r, state_nxt;
   logic [1:0]    sel_r, sel_nxt;
   logic [1:0]    idx_r, idx_nxt;
   logic          use_busy_r, use_busy_nxt;
   logic          seen_hi_r, seen_hi_nxt;
   logic [WW-1:0] cnt_r, cnt_nxt;
   logic          as_n_r, as_n_nxt;
   logic          rw_r, rw_nxt;
   logic [AW-1:0] addr_r, addr_nxt;
   logic          rd_n_r, rd_n_nxt;
   logic [3:0]    cs_n_r, cs_n_nxt;
   logic          convert_start_n_n_r, convert_start_n_n_nxt;
   logic          ack_n_r, ack_n_nxt;
   logic          active_r, active_nxt;
   logic          ext_fall, busy_sel, fifo_ready, push;
   logic [15:0]   push_data;

   always_comb begin
      state_nxt    = state_r;
      sel_nxt      = sel_r;
      idx_nxt      = idx_r;
      use_busy_nxt = use_busy_r;
      seen_hi_nxt  = seen_hi_r;
      cnt_nxt      = cnt_r;
      as_n_nxt     = 1'b1;
      rw_nxt       = 1'b1;
      addr_nxt     = adc_glue_pkg::IDLE_ADDR;
      push         = 1'b0;
      ext_fall     = ext_d_r && !ext_s2_r;
      busy_sel     = busy_s2_r[sel_r];
      push_data    = {sel_r, idx_r, data_s2_r};
      unique case (state_r)
         adc_glue_pkg::ST_IDLE: begin
            sel_nxt      = i_conv_sel;
            use_busy_nxt = i_use_busy;
            seen_hi_nxt  = 1'b0;
            idx_nxt      = 2'h0;
            if (i_start) begin
               cnt_nxt   = WW'(START_CYC - 1);
               state_nxt = adc_glue_pkg::ST_START;
               as_n_nxt  = 1'b0;
               rw_nxt    = 1'b0;
               addr_nxt  = adc_glue_pkg::START_ADDR;
            end else if (ext_fall) begin
               cnt_nxt   = WW'(WAIT_CYC - 1);
               state_nxt = adc_glue_pkg::ST_WAIT;
            end
         end
         adc_glue_pkg::ST_START: begin
            if (cnt_r == '0) begin
               cnt_nxt   = WW'(WAIT_CYC - 1);
               state_nxt = adc_glue_pkg::ST_WAIT;
            end else begin
               cnt_nxt  = cnt_r - 1'b1;
               as_n_nxt = 1'b0;
               rw_nxt   = 1'b0;
               addr_nxt = adc_glue_pkg::START_ADDR;
            end
         end
         adc_glue_pkg::ST_WAIT: begin
            // no bus cycle while converting
            if (busy_sel) begin
               seen_hi_nxt = 1'b1;
            end
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 1'b1;
            end
            // busy falling ends the wait, or the delay runs out
            if ((use_busy_r && seen_hi_r && !busy_sel) ||
                (!use_busy_r && cnt_r == '0)) begin
               state_nxt = adc_glue_pkg::ST_RDGAP;
            end
         end
         adc_glue_pkg::ST_RDADDR: begin
            as_n_nxt = 1'b0;
            addr_nxt = adc_glue_pkg::CONV_BASE + AW'(sel_r);
            if (!ack_n_r) begin
               state_nxt = adc_glue_pkg::ST_RDWAIT;
            end
         end
         adc_glue_pkg::ST_RDWAIT: begin
            // the extra wait state also lets the data synchroniser fill
            as_n_nxt  = 1'b0;
            addr_nxt  = adc_glue_pkg::CONV_BASE + AW'(sel_r);
            state_nxt = adc_glue_pkg::ST_RDTAKE;
         end
         adc_glue_pkg::ST_RDTAKE: begin
            push      = 1'b1;
            idx_nxt   = idx_r + 1'b1;
            state_nxt = (idx_r == 2'(adc_glue_pkg::NUM_RESULTS - 1)) ?
                        adc_glue_pkg::ST_IDLE :
                        adc_glue_pkg::ST_RDGAP;
         end
         adc_glue_pkg::ST_RDGAP: begin
            // a read starts only with room for its result
            if (fifo_ready) begin
               as_n_nxt  = 1'b0;
               addr_nxt  = adc_glue_pkg::CONV_BASE + AW'(sel_r);
               state_nxt = adc_glue_pkg::ST_RDADDR;
            end
         end
         default: begin
            state_nxt = adc_glue_pkg::ST_IDLE;
         end
      endcase
      rd_n_nxt     = as_n_nxt | !rw_nxt;
      convert_start_n_n_nxt = !(!as_n_nxt && !rw_nxt &&
                       addr_nxt == adc_glue_pkg::START_ADDR);
      ack_n_nxt    = &cs_n_r;
      active_nxt   = (state_nxt != adc_glue_pkg::ST_IDLE);
   end

   genvar g;
   generate
      for (g = 0; g < adc_glue_pkg::NUM_CONV; g++) begin : g_cs
         assign cs_n_nxt[g] = !(!as_n_nxt && rw_nxt && addr_nxt ==
                                adc_glue_pkg::CONV_BASE + AW'(g));
      end
   endgenerate

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r    <= adc_glue_pkg::ST_IDLE;
         sel_r      <= 2'h0;
         idx_r      <= 2'h0;
         use_busy_r <= 1'b0;
         seen_hi_r  <= 1'b0;
         cnt_r      <= '0;
         as_n_r     <= 1'b1;
         rw_r       <= 1'b1;
         addr_r     <= adc_glue_pkg::IDLE_ADDR;
         rd_n_r     <= 1'b1;
         cs_n_r     <= 4'hF;
         convert_start_n_n_r <= 1'b1;
         ack_n_r    <= 1'b1;
         active_r   <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         sel_r      <= sel_nxt;
         idx_r      <= idx_nxt;
         use_busy_r <= use_busy_nxt;
         seen_hi_r  <= seen_hi_nxt;
         cnt_r      <= cnt_nxt;
         as_n_r     <= as_n_nxt;
         rw_r       <= rw_nxt;
         addr_r     <= addr_nxt;
         rd_n_r     <= rd_n_nxt;
         cs_n_r     <= cs_n_nxt;
         convert_start_n_n_r <= convert_start_n_n_nxt;
         ack_n_r    <= ack_n_nxt;
         active_r   <= active_nxt;
      end
   end

   // ----------------------------------------------------------------
   // result buffer
   // ----------------------------------------------------------------
   result_fifo #(
      .WIDTH (adc_glue_pkg::RES_W),
      .DEPTH (adc_glue_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_nrst      (i_nrst),
      .i_in_valid  (push),
      .o_in_ready  (fifo_ready),
      .i_in_data   (push_data),
      .o_out_valid (o_res_valid),
      .i_out_ready (i_res_ready),
      .o_out_data  (o_res_data)
   );

   assign o_convert_start_n  = convert_start_n_n_r;
   assign o_rd_n             = rd_n_r;
   assign o_cs_n             = cs_n_r;
   assign o_address_strobe_n = as_n_r;
   assign o_rw               = rw_r;
   assign o_transfer_ack_n   = ack_n_r;
   assign o_active           = active_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_start_decode: assert property (
      @(posedge i_sys_clk) disable iff (!i_nrst)
      !convert_start_n_n_r |-> (!as_n_r && !rw_r && (&cs_n_r) &&
                       addr_r == adc_glue_pkg::START_ADDR))
      else $error("start strobe without decoded write");
   chk_rd_strobe_form: assert property (
      @(posedge i_sys_clk) disable iff (!i_nrst)
      !rd_n_r |-> (!as_n_r && rw_r && !(&cs_n_r)))
      else $error("read strobe without read cycle");
   chk_ack_from_cs: assert property (
      @(posedge i_sys_clk) disable iff (!i_nrst)
      $fell(&cs_n_r) |=> !ack_n_r)
      else $error("ack did not follow chip select");
   chk_no_read_conv: assert property (
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_r == adc_glue_pkg::ST_WAIT) |-> (rd_n_r && (&cs_n_r)))
      else $error("read during conversion");
   chk_wait_state: assert property (
      @(posedge i_sys_clk) disable iff (!i_nrst)
      $fell(ack_n_r) |=> (state_r == adc_glue_pkg::ST_RDWAIT) ##1
      (state_r == adc_glue_pkg::ST_RDTAKE && !rd_n_r))
      else $error("missing wait state");
   chk_one_cs: assert property (
      @(posedge i_sys_clk) disable iff (!i_nrst)
      !(&cs_n_r) |-> ($onehot0(~cs_n_r) && cs_n_r[sel_r] == 1'b0))
      else $error("wrong chip select");
   chk_same_addr: assert property (
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_r != adc_glue_pkg::ST_IDLE) |=> $stable(sel_r))
      else $error("converter changed mid sequence");
   chk_four_reads: assert property (
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_r == adc_glue_pkg::ST_RDTAKE && idx_r == 2'h3) |=>
      (state_r == adc_glue_pkg::ST_IDLE && idx_r == 2'h0))
      else $error("sequence not ended after fourth read");
   chk_busy_end: assert property (
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_r == adc_glue_pkg::ST_WAIT && use_busy_r && seen_hi_r &&
       !busy_sel) |=> (state_r == adc_glue_pkg::ST_RDGAP))
      else $error("busy end not acted on");
endmodule

// file: dv/adc_conv_model.sv
`timescale 1ns/10ps
module adc_conv_model #(
   parameter int CONV_CYC = 100
) (
   input  wire logic        i_sys_clk,         // system clock
   input  wire logic        i_nrst,            // async reset, active low
   input  wire logic        i_convert_start_n, // shared convert-start
   input  wire logic        i_rd_n,            // shared read strobe
   input  wire logic [3:0]  i_cs_n,            // chip selects
   input  wire logic [11:0] i_pattern,         // sample of this conversion
   output logic [3:0]       o_busy,            // busy pins
   output logic [11:0]      o_data             // shared data pins
);
   logic       prev_cv_n;
   logic       prev_rd_n;
   logic [3:0] prev_cs_n;
   int         cnt;
   logic [1:0] idx [4];
   logic [11:0] last;

   // ----------------------------------------------------------------
   // conversion timer and read sequence
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prev_cv_n = 1'b1;
         prev_rd_n = 1'b1;
         prev_cs_n = 4'hF;
         cnt = 0;
         for (int k = 0; k < 4; k++) idx[k] = 2'h0;
      end else begin
         if (prev_cv_n && !i_convert_start_n) begin
            cnt = CONV_CYC;
            for (int k = 0; k < 4; k++) idx[k] = 2'h0;
         end else if (cnt != 0) begin
            cnt = cnt - 1;
         end
         for (int k = 0; k < 4; k++) begin
            if (!prev_rd_n && i_rd_n && !prev_cs_n[k]) begin
               idx[k] = idx[k] + 2'h1;
            end
         end
         prev_cv_n = i_convert_start_n;
         prev_rd_n = i_rd_n;
         prev_cs_n = i_cs_n;
      end
   end

   // busy stays high until every result is ready
   assign o_busy = {4{cnt != 0}};

   // released pins show the inverse of the last value, never a hold
   always @* begin
      o_data = ~last;
      for (int k = 0; k < 4; k++) begin
         if (!i_rd_n && !i_cs_n[k]) begin
            o_data = i_pattern ^ {k[1:0], idx[k], 8'h00};
         end
      end
   end

   always @(posedge i_sys_clk) last <= o_data;
endmodule

// file: dv/adc_host_bus_glue_bench.sv
`timescale 1ns/10ps
module adc_host_bus_glue_bench;
   logic        i_sys_clk, i_nrst, i_start, i_use_busy, i_ext_start_n;
   logic        i_res_ready, rdy_en;
   logic [1:0]  i_conv_sel;
   logic [3:0]  i_busy, o_cs_n, prev_cs;
   logic [11:0] i_adc_data, pattern;
   logic        o_convert_start_n, o_rd_n, o_address_strobe_n, o_rw;
   logic        o_transfer_ack_n, o_active, o_res_valid;
   logic [15:0] o_res_data;
   logic [31:0] exp_w;
   logic [15:0] exp_q [$];
   int          failures, checked, seed, rd_len, cv_len;

   adc_host_bus_glue dut_u (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_start(i_start),
      .i_conv_sel(i_conv_sel), .i_use_busy(i_use_busy),
      .i_ext_start_n(i_ext_start_n), .i_busy(i_busy),
      .i_adc_data(i_adc_data), .o_convert_start_n(o_convert_start_n),
      .o_rd_n(o_rd_n), .o_cs_n(o_cs_n),
      .o_address_strobe_n(o_address_strobe_n), .o_rw(o_rw),
      .o_transfer_ack_n(o_transfer_ack_n), .o_active(o_active),
      .o_res_valid(o_res_valid), .i_res_ready(i_res_ready),
      .o_res_data(o_res_data));

   // the external timer drives the converters directly
   adc_conv_model model_u (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
      .i_convert_start_n(o_convert_start_n & i_ext_start_n),
      .i_rd_n(o_rd_n), .i_cs_n(o_cs_n), .i_pattern(pattern),
      .o_busy(i_busy), .o_data(i_adc_data));

   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wait_idle(input int lim);
      int n;
      n = 0;
      @(negedge i_sys_clk);
      while (o_active !== 1'b0 && n < lim) begin
         @(negedge i_sys_clk);
         n++;
      end
      check(o_active, 0);
   endtask

   task automatic run(input logic ext, input logic [1:0] sel,
                      input logic busy_mode);
      logic [11:0] d;
      @(posedge i_sys_clk);
      i_conv_sel <= sel;
      i_use_busy <= busy_mode;
      pattern    <= 12'($random(seed));
      @(posedge i_sys_clk);
      for (int i = 0; i < 4; i++) begin
         d = pattern ^ {sel, i[1:0], 8'h00};
         exp_q.push_back({sel, i[1:0], d});
      end
      if (ext) i_ext_start_n <= 1'b0;
      else i_start <= 1'b1;
      @(posedge i_sys_clk);
      i_start <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      i_ext_start_n <= 1'b1;
   endtask

   // ----------------------------------------------------------------
   // consumer, result compare and pin monitor
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk) i_res_ready <= rdy_en && ($random(seed) & 1);

   always @(negedge i_sys_clk) begin
      if (o_res_valid === 1'b1 && i_res_ready === 1'b1) begin
         exp_w = exp_q.size() ? 32'(exp_q.pop_front()) : 32'hFFFFFFFF;
         check(o_res_data, exp_w);
      end
      if (i_nrst) begin
         check(o_rd_n, o_address_strobe_n | !o_rw);
         check(o_transfer_ack_n, &prev_cs);
         if (!o_convert_start_n) begin
            check({o_rw, o_address_strobe_n, o_cs_n}, 6'h0F);
            cv_len++;
         end else begin
            if (cv_len != 0) check(cv_len, adc_glue_pkg::START_CYC);
            cv_len = 0;
         end
         if (!o_rd_n) begin
            check(o_cs_n, 4'(~(4'h1 << i_conv_sel)));
            check(i_busy, 4'h0);
            rd_len++;
         end else begin
            if (rd_len != 0) check(rd_len, 4);
            rd_len = 0;
         end
      end
      prev_cs = o_cs_n;
   end

   initial begin
      #(20 * 40000);
      failures++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32;
      failures = 0;
      checked = 0;
      rd_len = 0;
      cv_len = 0;
      prev_cs = 4'hF;
      i_nrst = 1'b0;
      i_start = 1'b0;
      i_conv_sel = 2'h0;
      i_use_busy = 1'b0;
      i_ext_start_n = 1'b1;
      pattern = 12'h000;
      rdy_en = 1'b0;
      repeat (10) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check({o_convert_start_n, o_rd_n, o_cs_n, o_address_strobe_n, o_rw,
             o_transfer_ack_n, o_active, o_res_valid}, 11'h7FC);
      check(o_res_data, 16'h0000);
      @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      rdy_en <= 1'b1;
      // every converter, busy wait and fixed delay, consumer stalling
      for (int s = 0; s < 8; s++) begin
         run(1'b0, s[1:0], s[2]);
         wait_idle(1000);
      end
      for (int s = 0; s < 4; s++) begin
         run(1'b1, s[1:0], 1'b0);
         wait_idle(1000);
      end
      // fill the buffer until reads are held off, then drain it
      repeat (100) @(posedge i_sys_clk);
      rdy_en <= 1'b0;
      for (int s = 0; s < 5; s++) begin
         run(1'b0, 2'h2, s[0]);
         if (s < 4) wait_idle(1000);
      end
      repeat (1000) @(negedge i_sys_clk);
      check(o_active, 1);
      check({o_rd_n, o_res_valid}, 2'h3);
      @(posedge i_sys_clk);
      rdy_en <= 1'b1;
      wait_idle(2000);
      repeat (300) @(negedge i_sys_clk);
      check(exp_q.size(), 0);
      wrap_up();
   end
endmodule
